/* hw/byte_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0]   count_q;
	logic          push;
	logic          pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_q];

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wr_ptr_q] <= in_data;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= ptr_inc(wr_ptr_q);
			if (pop)
				rd_ptr_q <= ptr_inc(rd_ptr_q);
		end
	end

	// Flags kept as flops so the producer sees a registered ready
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			count_q   <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			if (push && !pop)
			begin
				count_q   <= count_q + 1'b1;
				in_ready  <= (count_q + 1'b1) != FULL_CNT;
				out_valid <= 1'b1;
			end
			else if (pop && !push)
			begin
				count_q   <= count_q - 1'b1;
				in_ready  <= 1'b1;
				out_valid <= count_q != (AW+1)'(1);
			end
		end
	end
endmodule

/* hw/jtag_dbg_pkg.sv */
// Constants, opcodes and state codes of the debug and scan port
// Behaviour
// - Opcodes 0x8 to 0xB route the serial path to the debug system.
// - A program write stores the byte and sets the dirty flag.
// - CPU read gives seven low channel bits plus dirty flag on top.
// - Shared address reaches the channel only with fuse and debugger enable.
// - Port works only with enable fuse set and disable bit clear.
// - Lock bits block debug fuse programming until a chip erase.
// - Four port pins alone serve programming and verifying of memories; this design has no memory programming.
// - Identification is the default instruction after controller reset.
// - Entering reset puts every port pin output in high impedance; an active EXTEST still drives the pins here.
// - Loading EXTEST drives the output latch contents onto the pins.
// - Sample and preload snapshot the pins without disturbing the part.
// - Scan runs from the test clock, even faster than internal clock; here the test clock is sampled on the core clock and must be slower.
// - Bypass is one stage, cleared to zero at capture while selected.
// - Identification word holds version, part number, maker code fields.
// - A one in the reset register holds the device in reset.
// - After the reset register clears, reset stays for a fused time-out.
// - Reset register output is not latched; shifting acts at once.
// - Chain drives and observes digital pins and the analog interface.
// - Instruction register is four bits wide.
// - All shift registers move least significant bit first.
// - Chip reset instruction never resets the port state machine.
// - State machine steps on TMS at test clock rise, starts in reset.
package jtag_dbg_pkg;
	localparam int IR_W = 4;
	localparam logic [3:0] OP_EXTEST      = 4'h0;
	localparam logic [3:0] OP_IDCODE      = 4'h1;
	localparam logic [3:0] OP_SAMPLE      = 4'h2;
	localparam logic [3:0] OP_DBG_ZERO    = 4'h8;
	localparam logic [3:0] OP_DBG_ONE     = 4'h9;
	localparam logic [3:0] OP_DBG_TWO     = 4'hA;
	localparam logic [3:0] OP_DBG_THREE   = 4'hB;
	localparam logic [3:0] OP_CHIP_RESET  = 4'hC;
	localparam logic [3:0] OP_BYPASS      = 4'hF;
	localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;

	// Identity values are arbitrary
	localparam logic [3:0]  ID_VERSION  = 4'h5;
	localparam logic [15:0] ID_PART     = 16'h5A3C;
	localparam logic [10:0] ID_MAKER    = 11'h2A6;
	localparam int          ID_VER_LSB  = 28;
	localparam int          ID_PART_LSB = 12;
	localparam int          ID_MAKE_LSB = 1;

	localparam int SR_W     = 32;
	localparam int PINS     = 8;
	localparam int ANA      = 2;
	localparam int BSC_LEN  = 2 * PINS + ANA;
	localparam int DBG_LEN  = 9;
	localparam int DBG_CLR  = 8;
	localparam int BYTE_W   = 8;
	localparam int FIFO_DEP = 8;
	localparam int DIRTY_BIT    = 7;
	localparam int PORT_DIS_BIT = 7;

	localparam int CLK_PERIOD_NS = 10;
	localparam int TOUT_SHORT_US = 64;
	localparam int TOUT_LONG_US  = 4096;
	localparam int TOUT_SHORT_CYC = TOUT_SHORT_US * 1000 / CLK_PERIOD_NS;
	localparam int TOUT_LONG_CYC  = TOUT_LONG_US * 1000 / CLK_PERIOD_NS;
	localparam int TOUT_W = 20;

	typedef enum logic [3:0] {
		TAP_EX2_DR  = 4'b0000,
		TAP_EX1_DR  = 4'b0001,
		TAP_SH_DR   = 4'b0010,
		TAP_PA_DR   = 4'b0011,
		TAP_SEL_IR  = 4'b0100,
		TAP_UPD_DR  = 4'b0101,
		TAP_CAP_DR  = 4'b0110,
		TAP_SEL_DR  = 4'b0111,
		TAP_EX2_IR  = 4'b1000,
		TAP_EX1_IR  = 4'b1001,
		TAP_SH_IR   = 4'b1010,
		TAP_PA_IR   = 4'b1011,
		TAP_RTI     = 4'b1100,
		TAP_UPD_IR  = 4'b1101,
		TAP_CAP_IR  = 4'b1110,
		TAP_TLR     = 4'b1111
	} tap_state_t;
endpackage

/* hw/jtag_debug_scan.sv */
// Test access port with debug byte channel and scan data registers
`timescale 1ns/1ps
module jtag_debug_scan #(
	parameter logic [19:0] TOUT_SHORT = 20'(jtag_dbg_pkg::TOUT_SHORT_CYC),
	parameter logic [19:0] TOUT_LONG  = 20'(jtag_dbg_pkg::TOUT_LONG_CYC)
) (
	input  wire logic                            core_clk,
	input  wire logic                            rst_n,
	input  wire logic                            tck,
	input  wire logic                            tms,
	input  wire logic                            tdi,
	output logic                                 tdo,
	output logic                                 tdo_oe_n,
	input  wire logic                            port_enable_fuse,
	input  wire logic                            debug_enable_fuse,
	input  wire logic                            lock_bit_one,
	input  wire logic                            lock_bit_two,
	input  wire logic                            clk_opt_long,
	input  wire logic                            ext_reset_n,
	input  wire logic                            mcu_ctrl_wr,
	input  wire logic [jtag_dbg_pkg::BYTE_W-1:0] mcu_ctrl_wdata,
	output logic                                 port_disable_bit,
	output logic                                 port_active,
	input  wire logic                            io_addr_hit,
	input  wire logic                            io_wr,
	input  wire logic                            io_rd,
	input  wire logic [jtag_dbg_pkg::BYTE_W-1:0] io_wdata,
	output logic                                 io_wr_ready,
	output logic [jtag_dbg_pkg::BYTE_W-1:0]      io_rdata,
	output logic                                 debug_route,
	input  wire logic                            fuse_prog_req,
	input  wire logic                            chip_erase_done,
	output logic                                 fuse_prog_ack,
	output logic                                 fuse_prog_nak,
	output logic                                 chip_reset,
	input  wire logic [jtag_dbg_pkg::PINS-1:0]   pin_in,
	input  wire logic [jtag_dbg_pkg::PINS-1:0]   core_out,
	input  wire logic [jtag_dbg_pkg::PINS-1:0]   core_oe,
	output logic [jtag_dbg_pkg::PINS-1:0]        pad_out,
	output logic [jtag_dbg_pkg::PINS-1:0]        pad_oe_n,
	input  wire logic [jtag_dbg_pkg::ANA-1:0]    ana_in,
	input  wire logic [jtag_dbg_pkg::ANA-1:0]    core_ana_ctrl,
	output logic [jtag_dbg_pkg::ANA-1:0]         ana_ctrl
);
	import jtag_dbg_pkg::*;

	localparam logic [SR_W-1:0] ID_WORD = SR_W'(
		(32'(ID_VERSION) << ID_VER_LSB) |
		(32'(ID_PART) << ID_PART_LSB) |
		(32'(ID_MAKER) << ID_MAKE_LSB) | 32'h0000_0001);

	logic             tck_s1, tck_s2, tck_s3;
	logic             tms_s1, tms_s2;
	logic             tdi_s1, tdi_s2;
	logic             xrst_s1, xrst_s2;
	logic [PINS-1:0]  pin_s1, pin_s2;
	logic [ANA-1:0]   ana_s1, ana_s2;
	logic             tck_rise;
	logic             tck_fall;

	tap_state_t       state_q;
	logic [IR_W-1:0]  ir_sr_q;
	logic [IR_W-1:0]  ir_q;
	logic [SR_W-1:0]  dr_sr_q;
	logic [BSC_LEN-1:0] bs_latch_q;
	logic             reset_reg_q;
	logic             access_en_q;
	logic [BYTE_W-1:0] chan_q;
	logic             dirty_q;
	logic             erased_q;
	logic [TOUT_W-1:0] tout_cnt_q;
	logic             fifo_valid;
	logic [BYTE_W-1:0] fifo_data;
	logic             fifo_pop;
	logic             dbg_clear;
	logic             locked;

	function automatic tap_state_t tap_next(input tap_state_t s,
		input logic m);
		case (s)
			TAP_TLR:    tap_next = m ? TAP_TLR    : TAP_RTI;
			TAP_RTI:    tap_next = m ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
			TAP_PA_DR:  tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
			TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_IR: tap_next = m ? TAP_TLR    : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
			TAP_PA_IR:  tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
			TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
			default:    tap_next = TAP_TLR;
		endcase
	endfunction

	function automatic logic is_dbg(input logic [IR_W-1:0] op);
		is_dbg = (op == OP_DBG_ZERO) || (op == OP_DBG_ONE) ||
			(op == OP_DBG_TWO) || (op == OP_DBG_THREE);
	endfunction

	function automatic logic is_bsc(input logic [IR_W-1:0] op);
		is_bsc = (op == OP_EXTEST) || (op == OP_SAMPLE);
	endfunction

	// Serial length of the selected register; anything unknown is bypass
	function automatic int dr_len(input logic [IR_W-1:0] op);
		if (op == OP_IDCODE)
			dr_len = SR_W;
		else if (is_bsc(op))
			dr_len = BSC_LEN;
		else if (op == OP_DBG_ONE)
			dr_len = 1;
		else if (is_dbg(op))
			dr_len = DBG_LEN;
		else
			dr_len = 1;
	endfunction

	function automatic logic [SR_W-1:0] shift_in(input logic [SR_W-1:0] sr,
		input logic b, input int len);
		logic [SR_W-1:0] r;
		r = sr >> 1;
		r[len-1] = b;
		shift_in = r;
	endfunction

	assign tck_rise  = tck_s2 && !tck_s3;
	assign tck_fall  = !tck_s2 && tck_s3;
	assign locked    = lock_bit_one || lock_bit_two;
	assign fifo_pop  = fifo_valid && !dirty_q;
	assign dbg_clear = tck_rise && (state_q == TAP_UPD_DR) &&
		(ir_q == OP_DBG_ZERO) && dr_sr_q[DBG_CLR];

	// Pins sampled on the core clock; the test clock is treated as data
	always_ff @(posedge core_clk)
	begin
		tck_s1  <= tck;
		tck_s2  <= tck_s1;
		tck_s3  <= tck_s2;
		tms_s1  <= tms;
		tms_s2  <= tms_s1;
		tdi_s1  <= tdi;
		tdi_s2  <= tdi_s1;
		xrst_s1 <= ext_reset_n;
		xrst_s2 <= xrst_s1;
		pin_s1  <= pin_in;
		pin_s2  <= pin_s1;
		ana_s1  <= ana_in;
		ana_s2  <= ana_s1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			port_disable_bit <= 1'b0;
			port_active      <= 1'b0;
		end
		else
		begin
			if (mcu_ctrl_wr)
				port_disable_bit <= mcu_ctrl_wdata[PORT_DIS_BIT];
			port_active <= port_enable_fuse && !port_disable_bit;
		end
	end

	// Only power-on reset and an inactive port (enable fuse clear or disable bit set) restart the controller
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !port_active)
			state_q <= TAP_TLR;
		else if (tck_rise)
			state_q <= tap_next(state_q, tms_s2);
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !port_active)
		begin
			ir_sr_q <= IR_CAPTURE_VAL;
			ir_q    <= OP_IDCODE;
		end
		else if (tck_rise)
		begin
			case (state_q)
				TAP_TLR:    ir_q    <= OP_IDCODE;
				TAP_CAP_IR: ir_sr_q <= IR_CAPTURE_VAL;
				TAP_SH_IR:  ir_sr_q <= {tdi_s2, ir_sr_q[IR_W-1:1]};
				TAP_UPD_IR: ir_q    <= ir_sr_q;
				default:    ir_q    <= ir_q;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			dr_sr_q <= '0;
		else if (tck_rise && state_q == TAP_CAP_DR)
		begin
			if (ir_q == OP_IDCODE)
				dr_sr_q <= ID_WORD;
			else if (is_bsc(ir_q))
				dr_sr_q <= SR_W'({ana_s2, ~pad_oe_n, pin_s2});
			else if (is_dbg(ir_q) && ir_q != OP_DBG_ONE)
				dr_sr_q <= SR_W'({dirty_q, chan_q});
			else
				dr_sr_q <= '0;
		end
		else if (tck_rise && state_q == TAP_SH_DR)
			dr_sr_q <= shift_in(dr_sr_q, tdi_s2, dr_len(ir_q));
	end

	// Shifts straight into the reset path, no update stage
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			reset_reg_q <= 1'b0;
		else if (tck_rise && state_q == TAP_SH_DR && ir_q == OP_CHIP_RESET)
			reset_reg_q <= tdi_s2;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			bs_latch_q  <= '0;
			access_en_q <= 1'b0;
		end
		else if (tck_rise && state_q == TAP_UPD_DR)
		begin
			if (is_bsc(ir_q))
				bs_latch_q <= dr_sr_q[BSC_LEN-1:0];
			if (ir_q == OP_DBG_ONE)
				access_en_q <= dr_sr_q[0];
		end
	end

	// Output changes on the falling test clock, as a TDO should
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !port_active)
		begin
			tdo      <= 1'b1;
			tdo_oe_n <= 1'b1;
		end
		else if (tck_fall)
		begin
			if (state_q == TAP_SH_IR)
			begin
				tdo      <= ir_sr_q[0];
				tdo_oe_n <= 1'b0;
			end
			else if (state_q == TAP_SH_DR)
			begin
				tdo      <= (ir_q == OP_CHIP_RESET) ? reset_reg_q : dr_sr_q[0];
				tdo_oe_n <= 1'b0;
			end
			else
				tdo_oe_n <= 1'b1;
		end
	end

	byte_fifo #(
		.W (BYTE_W),
		.D (FIFO_DEP)
	) u_chan_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (io_wr && io_addr_hit && debug_route),
		.in_ready  (io_wr_ready),
		.in_data   (io_wdata),
		.out_valid (fifo_valid),
		.out_ready (!dirty_q),
		.out_data  (fifo_data)
	);

	// Next byte waits until the debugger has taken the previous one
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			chan_q  <= '0;
			dirty_q <= 1'b0;
		end
		else if (fifo_pop)
		begin
			chan_q  <= fifo_data;
			dirty_q <= 1'b1;
		end
		else if (dbg_clear)
			dirty_q <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			io_rdata    <= '0;
			debug_route <= 1'b0;
		end
		else
		begin
			debug_route <= debug_enable_fuse && access_en_q && !locked;
			if (io_rd && io_addr_hit && debug_route)
				io_rdata <= {dirty_q, chan_q[DIRTY_BIT-1:0]};
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			erased_q      <= 1'b0;
			fuse_prog_ack <= 1'b0;
			fuse_prog_nak <= 1'b0;
		end
		else
		begin
			if (chip_erase_done)
				erased_q <= 1'b1;
			fuse_prog_ack <= fuse_prog_req && (!locked || erased_q);
			fuse_prog_nak <= fuse_prog_req && locked && !erased_q;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			tout_cnt_q <= '0;
			chip_reset <= 1'b1;
		end
		else
		begin
			if (reset_reg_q || !xrst_s2)
				tout_cnt_q <= clk_opt_long ? TOUT_LONG : TOUT_SHORT;
			else if (tout_cnt_q != '0)
				tout_cnt_q <= tout_cnt_q - 1'b1;
			chip_reset <= reset_reg_q || !xrst_s2 ||
				tout_cnt_q != '0;
		end
	end

	// Scan drive overrides the reset float so board test works in reset
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pad_out  <= '0;
			pad_oe_n <= '1;
			ana_ctrl <= '0;
		end
		else if (port_active && ir_q == OP_EXTEST)
		begin
			pad_out  <= bs_latch_q[PINS-1:0];
			pad_oe_n <= ~bs_latch_q[2*PINS-1:PINS];
			ana_ctrl <= bs_latch_q[BSC_LEN-1:2*PINS];
		end
		else if (chip_reset)
		begin
			pad_out  <= core_out;
			pad_oe_n <= '1;
			ana_ctrl <= core_ana_ctrl;
		end
		else
		begin
			pad_out  <= core_out;
			pad_oe_n <= ~core_oe;
			ana_ctrl <= core_ana_ctrl;
		end
	end

endmodule

/* verif/scan_checker.sv */
// Concurrent checks on the debug and scan port top-level pins
`timescale 1ns/1ps
module scan_checker #(
	parameter logic [19:0] TOUT_SHORT = 20'h14
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic tck,
	input wire logic tdo,
	input wire logic tdo_oe_n,
	input wire logic port_enable_fuse,
	input wire logic port_disable_bit,
	input wire logic port_active,
	input wire logic debug_enable_fuse,
	input wire logic lock_bit_one,
	input wire logic lock_bit_two,
	input wire logic debug_route,
	input wire logic ext_reset_n,
	input wire logic chip_reset,
	input wire logic fuse_prog_req,
	input wire logic chip_erase_done,
	input wire logic fuse_prog_ack,
	input wire logic fuse_prog_nak
);
	logic [19:0] hi_q;
	logic        ran_q;
	logic        erased_q;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// Power-up release has no time-out, so only falls after a low count
	always_ff @(posedge core_clk)
	begin
		hi_q <= (rst_n && chip_reset) ? hi_q + 20'h1 : 20'h0;
		ran_q <= rst_n && (ran_q || !chip_reset);
		erased_q <= rst_n && (erased_q || chip_erase_done);
	end

	sequence s_port_off;
		(!port_enable_fuse || port_disable_bit) [*2];
	endsequence
	sequence s_ext_low;
		!ext_reset_n [*6];
	endsequence
	sequence s_req_locked;
		fuse_prog_req && !erased_q && (lock_bit_one || lock_bit_two);
	endsequence
	sequence s_req_free;
		fuse_prog_req && (erased_q || !lock_bit_one && !lock_bit_two);
	endsequence
	sequence s_route_off;
		(!debug_enable_fuse || lock_bit_one || lock_bit_two) [*2];
	endsequence

	a_port_gate: assert property (s_port_off |-> !port_active)
		else $error("port active while fuse off or disabled");
	a_idle_quiet: assert property (!port_active [*3] |-> tdo_oe_n)
		else $error("test data driven while port inactive");
	a_lock_refuse: assert property (s_req_locked |=>
		fuse_prog_nak && !fuse_prog_ack)
		else $error("debug fuse programming not refused");
	a_prog_grant: assert property (s_req_free |=>
		fuse_prog_ack && !fuse_prog_nak)
		else $error("debug fuse programming not granted");
	a_route_gate: assert property (s_route_off |-> !debug_route)
		else $error("channel reachable without enable");
	a_reset_tout: assert property ($fell(chip_reset) && ran_q |->
		hi_q >= TOUT_SHORT)
		else $error("chip reset released before time-out");
	a_ext_hold: assert property (s_ext_low |-> chip_reset)
		else $error("external reset pin not honoured");
	a_tdo_fall: assert property (!tdo_oe_n && $changed(tdo) |-> !tck)
		else $error("test data changed while test clock high");
endmodule

bind jtag_debug_scan scan_checker #(
	.TOUT_SHORT(TOUT_SHORT)
) i_scan_checker (
	.core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tdo(tdo),
	.tdo_oe_n(tdo_oe_n), .port_enable_fuse(port_enable_fuse),
	.port_disable_bit(port_disable_bit), .port_active(port_active),
	.debug_enable_fuse(debug_enable_fuse), .lock_bit_one(lock_bit_one),
	.lock_bit_two(lock_bit_two), .debug_route(debug_route),
	.ext_reset_n(ext_reset_n), .chip_reset(chip_reset),
	.fuse_prog_req(fuse_prog_req), .chip_erase_done(chip_erase_done),
	.fuse_prog_ack(fuse_prog_ack), .fuse_prog_nak(fuse_prog_nak)
);

/* verif/tap_host_model.sv */
// Behavioural scan controller driving the test port pins
`timescale 1ns/1ps
module tap_host_model (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdo_oe_n
);
	// Clock rests low between frames; tms and tdi sit at pull-up level
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#80;
		tck = 1'b1;
		// Released test output reads as its pull-up level
		o = tdo_oe_n ? 1'b1 : tdo;
		#80;
		tck = 1'b0;
	endtask

	task automatic to_idle();
		logic o;
		repeat (5) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask

	task automatic scan(input logic ir, input logic [79:0] din,
		input int n, output logic [79:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b1, o);
		if (ir)
			step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask
endmodule

/* verif/testbench.sv */
// Self-checking bench for the debug and scan port
`timescale 1ns/1ps
module testbench;
	import jtag_dbg_pkg::*;
	typedef struct packed {
		logic [3:0] op;
		logic [7:0] len;
	} row_t;
	logic        core_clk, rst_n, tck, tms, tdi, tdo, tdo_oe_n, chip_reset;
	logic        port_enable_fuse, debug_enable_fuse, clk_opt_long;
	logic        lock_bit_one, lock_bit_two, ext_reset_n, mcu_ctrl_wr;
	logic        port_disable_bit, port_active, io_addr_hit, io_wr, io_rd;
	logic        io_wr_ready, debug_route, fuse_prog_req, chip_erase_done;
	logic        fuse_prog_ack, fuse_prog_nak;
	logic [7:0]  mcu_ctrl_wdata, io_wdata, io_rdata, pin_in, core_out;
	logic [7:0]  core_oe, pad_out, pad_oe_n;
	logic [1:0]  ana_in, core_ana_ctrl, ana_ctrl;
	logic [79:0] d;
	logic [8:0]  e;
	int          mismatches, checks_done, k;
	// Reset code last: it leaves the reset register set
	// Sample row first so the output latch is preloaded before EXTEST
	row_t rows [11] = '{'{OP_SAMPLE, 8'h12}, '{OP_IDCODE, 8'h20},
		'{OP_EXTEST, 8'h12}, '{4'h3, 8'h01}, '{OP_DBG_ZERO, 8'h09},
		'{OP_DBG_TWO, 8'h09}, '{OP_DBG_THREE, 8'h09}, '{OP_BYPASS, 8'h01},
		'{4'hE, 8'h01}, '{OP_DBG_ONE, 8'h01}, '{OP_CHIP_RESET, 8'h01}};

	jtag_debug_scan #(.TOUT_SHORT(20'h14), .TOUT_LONG(20'hC8))
		i_jtag_debug_scan (.*);
	tap_host_model i_tap_host_model (.*);

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic cpu(input logic wr, input logic [7:0] b);
		@(negedge core_clk);
		{io_addr_hit, io_wr, io_rd, io_wdata} = {1'b1, wr, !wr, b};
		@(negedge core_clk);
		{io_addr_hit, io_wr, io_rd} = 3'h0;
		repeat (2) @(negedge core_clk);
	endtask

	task automatic mcu(input logic [7:0] b);
		@(negedge core_clk);
		{mcu_ctrl_wr, mcu_ctrl_wdata} = {1'b1, b};
		@(negedge core_clk);
		mcu_ctrl_wr = 1'b0;
		repeat (3) @(negedge core_clk);
	endtask

	task automatic prog(input logic ok);
		@(negedge core_clk);
		fuse_prog_req = 1'b1;
		@(negedge core_clk);
		fuse_prog_req = 1'b0;
		chk("fuse_prog_ack", ok, fuse_prog_ack);
		chk("fuse_prog_nak", !ok, fuse_prog_nak);
	endtask

	task automatic wait_drop();
		int n;
		n = 0;
		while (chip_reset !== 1'b0 && n < 600)
		begin
			@(negedge core_clk);
			n++;
		end
		chk("chip_reset_release", 1'b0, chip_reset);
		if (n >= 600)
			print_verdict();
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever
			#5 core_clk = ~core_clk;
	end

	initial
	begin
		{rst_n, lock_bit_one, lock_bit_two, clk_opt_long, mcu_ctrl_wr} = '0;
		{io_addr_hit, io_wr, io_rd, fuse_prog_req, chip_erase_done} = '0;
		{port_enable_fuse, debug_enable_fuse, ext_reset_n} = 3'h7;
		{mcu_ctrl_wdata, io_wdata, pin_in, core_out} = 32'h0000_3CC3;
		{core_oe, ana_in, core_ana_ctrl} = 12'h0F6;
		mismatches = 0;
		checks_done = 0;
		repeat (8) @(negedge core_clk);
		chk("pad_oe_n", 8'hFF, pad_oe_n);
		chk("tdo_oe_n", 1'b1, tdo_oe_n);
		rst_n = 1'b1;
		repeat (8) @(negedge core_clk);
		chk("port_active", 1'b1, port_active);
		i_tap_host_model.to_idle();
		i_tap_host_model.scan(1'b0, '0, 32, d);
		chk("id_word", {ID_VERSION, ID_PART, ID_MAKER, 1'b1},
			d[31:0]);
		foreach (rows[r])
		begin
			i_tap_host_model.scan(1'b1, 80'(rows[r].op), 4, d);
			chk("ir_capture", IR_CAPTURE_VAL, d[3:0]);
			i_tap_host_model.scan(1'b0, {40'hFF_FFFF_FFFF, 40'h0}, 80,
				d);
			k = 40;
			while (k < 79 && d[k] !== 1'b1)
				k++;
			chk("dr_length", rows[r].len, k - 40);
			if (rows[r].op inside {OP_BYPASS, 4'hE, 4'h3})
				chk("bypass_capture", 1'b0, d[0]);
		end
		chk("chip_reset", 1'b1, chip_reset);
		chk("pad_oe_n", 8'hFF, pad_oe_n);
		clk_opt_long = 1'b1;
		i_tap_host_model.scan(1'b0, '0, 1, d);
		chk("chip_reset", 1'b1, chip_reset);
		wait_drop();
		ext_reset_n = 1'b0;
		repeat (10) @(negedge core_clk);
		ext_reset_n = 1'b1;
		repeat (20) @(negedge core_clk);
		chk("chip_reset", 1'b1, chip_reset);
		wait_drop();
		chk("debug_route", 1'b1, debug_route);
		cpu(1'b1, 8'h35);
		cpu(1'b0, 8'h00);
		chk("io_rdata", 8'hB5, io_rdata);
		for (k = 0; k < 9; k++)
			cpu(1'b1, 8'h10 + 8'(k));
		chk("io_wr_ready", 1'b0, io_wr_ready);
		i_tap_host_model.scan(1'b1, 80'(OP_DBG_ZERO), 4, d);
		for (k = 0; k < 10; k++)
		begin
			i_tap_host_model.scan(1'b0, 80'h100, 9, d);
			e = (k == 0) ? 9'h135 : (k < 9) ? 9'h10F + 9'(k) : 9'h017;
			chk("debug_dr", e, d[8:0]);
		end
		chk("io_wr_ready", 1'b1, io_wr_ready);
		debug_enable_fuse = 1'b0;
		repeat (3) @(negedge core_clk);
		chk("debug_route", 1'b0, debug_route);
		cpu(1'b1, 8'h66);
		debug_enable_fuse = 1'b1;
		repeat (3) @(negedge core_clk);
		cpu(1'b0, 8'h00);
		chk("io_rdata", 8'h17, io_rdata);
		i_tap_host_model.scan(1'b1, 80'(OP_SAMPLE), 4, d);
		i_tap_host_model.scan(1'b0, 80'h2_FF5A, 18, d);
		chk("sample_pins", {ana_in, core_oe, pin_in}, d[17:0]);
		chk("pad_out", core_out, pad_out);
		i_tap_host_model.scan(1'b1, 80'(OP_EXTEST), 4, d);
		chk("extest_pads", 18'h2_FF5A,
			{ana_ctrl, ~pad_oe_n, pad_out});
		i_tap_host_model.scan(1'b1, 80'(OP_BYPASS), 4, d);
		mcu(8'h80);
		chk("port_disable_bit", 1'b1, port_disable_bit);
		chk("port_active", 1'b0, port_active);
		mcu(8'h00);
		lock_bit_one = 1'b1;
		repeat (3) @(negedge core_clk);
		chk("debug_route", 1'b0, debug_route);
		prog(1'b0);
		{lock_bit_one, lock_bit_two} = 2'h1;
		prog(1'b0);
		chip_erase_done = 1'b1;
		@(negedge core_clk);
		chip_erase_done = 1'b0;
		prog(1'b1);
		// Mid-run reset must drop the erase record and access enable
		rst_n = 1'b0;
		repeat (4) @(negedge core_clk);
		chk("pad_oe_n", 8'hFF, pad_oe_n);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		chk("debug_route", 1'b0, debug_route);
		prog(1'b0);
		print_verdict();
	end
endmodule
